// file: ddis_pkg.sv
// Shared constants for the converter and digital I/O interrupt status block.
package ddis_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int DIO_N  = 20;
    localparam int DAC_N  = 4;

    ////////////////////////////////////////////////////////////////////////////
    localparam logic [11:0] OFF_ERR_EN  = 12'h370;
    localparam logic [11:0] OFF_RISE_EN = 12'h374;
    localparam logic [11:0] OFF_FALL_EN = 12'h378;
    localparam logic [11:0] OFF_MAIN_EN = 12'h37C;
    localparam logic [11:0] OFF_MAIN    = 12'h384;
    localparam logic [11:0] OFF_ERR     = 12'h388;
    localparam logic [11:0] OFF_DIO     = 12'h38C;
    localparam logic [11:0] OFF_GCFG    = 12'h398;

    ////////////////////////////////////////////////////////////////////////////
    localparam int MAIN_DIO_SUM  = 31;
    localparam int MAIN_ERR_SUM  = 30;
    localparam int MAIN_FTIM     = 29;
    localparam int MAIN_FTRIG    = 28;
    localparam int MAIN_CONV_LSB = 16;
    localparam int MAIN_SEQ_DONE = 4;
    localparam int MAIN_BUF_DONE = 0;
    localparam int ERR_FRAME     = 19;
    localparam int ERR_TIME      = 18;
    localparam int ERR_DATA      = 17;
    localparam int ERR_XFER      = 16;
    localparam int ERR_FAULT_LSB = 0;
    localparam int GCFG_ACK      = 0;

    localparam logic [31:0] MAIN_LATCH_MASK = 32'h300F_0011;
    localparam logic [31:0] ERR_MASK        = 32'h000F_000F;
    localparam logic [31:0] DIO_MASK        = 32'h000F_FFFF;
    localparam logic [31:0] GCFG_MASK       = 32'h0000_0001;
    localparam logic [31:0] RST_ZERO        = 32'h0000_0000;

    localparam logic ACK_READ  = 1'b0;
    localparam logic ACK_WRITE = 1'b1;

endpackage

// file: ddis_dio_if.sv
// Carrier between the register front end and the digital I/O flag bank.
`timescale 1ns/100ps
interface ddis_dio_if;
    import ddis_pkg::*;
    logic [DIO_N-1:0] rise_en;
    logic [DIO_N-1:0] fall_en;
    logic [DIO_N-1:0] clr;
    logic [DIO_N-1:0] flags;
    modport ctl (output rise_en, output fall_en, output clr, input flags);
    modport flg (input rise_en, input fall_en, input clr, output flags);
endinterface

// file: ddis_dio_flags.sv
// Edge-triggered sticky flags for the digital I/O inputs.
`timescale 1ns/100ps
module ddis_dio_flags
    import ddis_pkg::*;
(
    input wire logic             pclk,
    input wire logic             presetn,
    input wire logic [DIO_N-1:0] dio_in,
    ddis_dio_if.flg              dio
);

    typedef struct packed {
        logic [DIO_N-1:0] prev;
        logic [DIO_N-1:0] flags;
    } ddis_dio_state_t;

    ddis_dio_state_t s;
    ddis_dio_state_t next_s;
    logic [DIO_N-1:0] edge_set;

    ////////////////////////////////////////////////////////////////////////////
    // An event in the same cycle as a clear survives, the set wins.
    always_comb begin
        next_s = s;
        edge_set = (dio.rise_en & dio_in & ~s.prev)  // R18
                 | (dio.fall_en & ~dio_in & s.prev); // R18
        next_s.prev  = dio_in;
        next_s.flags = (s.flags & ~dio.clr) | edge_set;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign dio.flags = s.flags;

    ////////////////////////////////////////////////////////////////////////////
    a_dio_rise_set: assert property (@(posedge pclk) disable iff (!presetn) // R18
        (dio.rise_en[0] && dio_in[0] && !s.prev[0]) |=> s.flags[0])
        else $error("rising edge did not set digital input flag");

    a_dio_fall_set: assert property (@(posedge pclk) disable iff (!presetn) // R18
        (dio.fall_en[0] && !dio_in[0] && s.prev[0]) |=> s.flags[0])
        else $error("falling edge did not set digital input flag");

endmodule // ddis_dio_flags

// file: ddis_top.sv
// APB interrupt status gathering for the converter and digital I/O board.
// Summary of operation
// [R01] Interrupt active while any main status bit set.
// [R02] Flags set only if enabled before event; error bit 16 (transfer error) is set without an enable.
// [R03] Acknowledge method chosen by configuration register.
// [R04] Bit 31 summarises digital I/O flags.
// [R05] Bit 30 summarises error status flags.
// [R06] Bit 29 latches frame timer expiry.
// [R07] Bit 28 latches frame trigger events.
// [R08] Bits 16-19 latch converter output updates.
// [R09] Update flags intended for manual update mode.
// [R10] Bit 4 latches sequencer conversions complete.
// [R11] Bit 0 latches sequencer buffer complete.
// [R12] Error bit 19 frame error; sequencer stops.
// [R13] Error bit 18 timing error; sequencer halts.
// [R14] Error bit 17 latches sequencer data error.
// [R15] Error bit 16 transfer error; engine stops.
// [R16] Error bits 0-3 latch converter fault pins.
// [R17] Per-converter fault enables gate flags, reset 0.
// [R18] Digital flags set on selected input edges.
// [R19] Read returns flags, then clears them.
// [R20] Reserved status bits read 0, ignore writes.
`timescale 1ns/100ps
module ddis_top
    import ddis_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [DATA_W-1:0] pwdata,
    output logic      [DATA_W-1:0] prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              frame_timer_evt,
    input  wire logic              frame_trig_evt,
    input  wire logic [DAC_N-1:0]  dac_conv_evt,
    input  wire logic              seq_conv_done_evt,
    input  wire logic              seq_buf_done_evt,
    input  wire logic              seq_frame_err_evt,
    input  wire logic              seq_time_err_evt,
    input  wire logic              seq_data_err_evt,
    input  wire logic              seq_xfer_err_evt,
    input  wire logic [DAC_N-1:0]  dac_fault_n,
    input  wire logic [DIO_N-1:0]  dio_in,
    output logic                   irq_n,
    output logic                   seq_stop,
    output logic                   dma_stop
);

    typedef struct packed {
        logic              pready;
        logic              pslverr;
        logic [DATA_W-1:0] prdata;
        logic [DATA_W-1:0] main_en;
        logic [DATA_W-1:0] err_en;
        logic [DIO_N-1:0]  rise_en;
        logic [DIO_N-1:0]  fall_en;
        logic              ack_mode;
        logic [DATA_W-1:0] main;
        logic [DATA_W-1:0] err;
        logic [DAC_N-1:0]  fault_prev;
        logic              irq_n;
        logic              seq_stop;
        logic              dma_stop;
    } ddis_top_state_t;

    ddis_top_state_t   s;
    ddis_top_state_t   next_s;
    ddis_dio_if        dio ();
    logic              setup;
    logic              access;
    logic              hit;
    logic [DATA_W-1:0] rd;
    logic [DATA_W-1:0] main_view;
    logic [DATA_W-1:0] main_set;
    logic [DATA_W-1:0] err_set;
    logic [DATA_W-1:0] main_clr;
    logic [DATA_W-1:0] err_clr;
    logic [DATA_W-1:0] dio_clr;
    logic [DATA_W-1:0] dio_word;

    ////////////////////////////////////////////////////////////////////////////
    ddis_dio_flags u_dio (
        .pclk    (pclk),
        .presetn (presetn),
        .dio_in  (dio_in),
        .dio     (dio.flg)
    );

    assign dio.rise_en = s.rise_en;
    assign dio.fall_en = s.fall_en;
    assign dio.clr     = dio_clr[DIO_N-1:0];
    assign dio_word    = {{(DATA_W-DIO_N){1'b0}}, dio.flags};

    ////////////////////////////////////////////////////////////////////////////
    // Summary bits are computed on the fly so they can never go stale.
    always_comb begin
        main_view = s.main & MAIN_LATCH_MASK; // R20
        main_view[MAIN_DIO_SUM] = |dio.flags; // R04
        main_view[MAIN_ERR_SUM] = |(s.err & ERR_MASK); // R05
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register decode; read data is captured in the setup cycle and the slave
    // answers in the first access cycle with no wait state, so every bus output comes from a flip-flop.
    always_comb begin
        hit = 1'b1;
        rd  = RST_ZERO;
        unique case (paddr)
            OFF_ERR_EN:  rd = s.err_en & ERR_MASK;
            OFF_RISE_EN: rd = {{(DATA_W-DIO_N){1'b0}}, s.rise_en};
            OFF_FALL_EN: rd = {{(DATA_W-DIO_N){1'b0}}, s.fall_en};
            OFF_MAIN_EN: rd = s.main_en & MAIN_LATCH_MASK;
            OFF_MAIN:    rd = main_view;
            OFF_ERR:     rd = s.err & ERR_MASK; // R20
            OFF_DIO:     rd = dio_word & DIO_MASK;
            OFF_GCFG:    rd = {{(DATA_W-1){1'b0}}, s.ack_mode};
            default:     hit = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_s = s;
        setup  = psel & ~penable;
        access = psel & penable & s.pready;

        next_s.pready  = setup;
        next_s.pslverr = setup & ~hit;
        next_s.prdata  = (setup & ~pwrite) ? rd : RST_ZERO;

        // Enables are the values held before this cycle, so an event arriving
        // with the enabling write leaves no record.
        main_set = RST_ZERO;
        main_set[MAIN_FTIM]  = frame_timer_evt & s.main_en[MAIN_FTIM];  // R06 R02
        main_set[MAIN_FTRIG] = frame_trig_evt & s.main_en[MAIN_FTRIG]; // R07 R02
        // Sequencer-driven updates also set these; software should ignore them then.
        main_set[MAIN_CONV_LSB +: DAC_N] =
            dac_conv_evt & s.main_en[MAIN_CONV_LSB +: DAC_N]; // R08 R09
        main_set[MAIN_SEQ_DONE] = seq_conv_done_evt & s.main_en[MAIN_SEQ_DONE]; // R10
        main_set[MAIN_BUF_DONE] = seq_buf_done_evt & s.main_en[MAIN_BUF_DONE];  // R11

        err_set = RST_ZERO;
        err_set[ERR_FRAME] = seq_frame_err_evt & s.err_en[ERR_FRAME]; // R12
        err_set[ERR_TIME]  = seq_time_err_evt & s.err_en[ERR_TIME];   // R13
        err_set[ERR_DATA]  = seq_data_err_evt & s.err_en[ERR_DATA];   // R14
        // The transfer error is recorded without an enable gate.
        err_set[ERR_XFER]  = seq_xfer_err_evt; // R15
        err_set[ERR_FAULT_LSB +: DAC_N] = s.fault_prev & ~dac_fault_n
            & s.err_en[ERR_FAULT_LSB +: DAC_N]; // R16 R17

        // Read-clear only drops the bits that were returned, so an event that
        // lands between capture and completion is kept.
        main_clr = RST_ZERO;
        err_clr  = RST_ZERO;
        dio_clr  = RST_ZERO;
        if (access) begin
            if (!pwrite && s.ack_mode == ACK_READ) begin // R03
                unique case (paddr)
                    OFF_MAIN: main_clr = s.prdata; // R19
                    OFF_ERR:  err_clr  = s.prdata; // R19
                    OFF_DIO:  dio_clr  = s.prdata; // R19
                    default:  main_clr = RST_ZERO;
                endcase
            end
            if (pwrite && s.ack_mode == ACK_WRITE) begin // R03
                unique case (paddr)
                    OFF_MAIN: main_clr = pwdata;
                    OFF_ERR:  err_clr  = pwdata;
                    OFF_DIO:  dio_clr  = pwdata;
                    default:  main_clr = RST_ZERO;
                endcase
            end
            if (pwrite) begin
                unique case (paddr)
                    OFF_ERR_EN:  next_s.err_en  = pwdata & ERR_MASK; // R17
                    OFF_RISE_EN: next_s.rise_en = pwdata[DIO_N-1:0];
                    OFF_FALL_EN: next_s.fall_en = pwdata[DIO_N-1:0];
                    OFF_MAIN_EN: next_s.main_en = pwdata & MAIN_LATCH_MASK;
                    OFF_GCFG:    next_s.ack_mode = pwdata[GCFG_ACK];
                    default:     next_s.ack_mode = s.ack_mode;
                endcase
            end
        end

        next_s.main = ((s.main & ~main_clr) | main_set) & MAIN_LATCH_MASK; // R20
        next_s.err  = ((s.err & ~err_clr) | err_set) & ERR_MASK;         // R20
        next_s.fault_prev = dac_fault_n;
        next_s.irq_n    = ~(|main_view); // R01
        next_s.seq_stop = seq_frame_err_evt | seq_time_err_evt; // R12 R13
        next_s.dma_stop = seq_xfer_err_evt; // R15
    end

    ////////////////////////////////////////////////////////////////////////////
    // The fault history resets high so a pin already low at release counts
    // as a fresh assertion.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.fault_prev <= '1;
            s.irq_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign prdata   = s.prdata;
    assign pready   = s.pready;
    assign pslverr  = s.pslverr;
    assign irq_n    = s.irq_n;
    assign seq_stop = s.seq_stop;
    assign dma_stop = s.dma_stop;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_latch(logic evt, logic en, logic flag);
        (evt && en) |=> flag;
    endproperty

    a_irq_follows: assert property (irq_n == !$past(|main_view)) // R01
        else $error("interrupt output does not track status");

    a_no_set_disabled: assert property ( // R02
        (!s.main_en[MAIN_FTIM] && !s.main[MAIN_FTIM]) |=> !s.main[MAIN_FTIM])
        else $error("disabled timer flag became set");

    a_ack_write_clear: assert property ( // R03
        (access && pwrite && paddr == OFF_MAIN && s.ack_mode == ACK_WRITE
         && pwdata[MAIN_FTIM] && !frame_timer_evt) |=> !s.main[MAIN_FTIM])
        else $error("write-one clear failed");

    a_summary_bits: assert property ( // R04 R05
        (setup && !pwrite && paddr == OFF_MAIN) |=>
        (prdata[MAIN_DIO_SUM] == $past(|dio.flags))
        && (prdata[MAIN_ERR_SUM] == $past(|s.err)))
        else $error("summary bits wrong");

    a_timer_latch: assert property ( // R06
        p_latch(frame_timer_evt, s.main_en[MAIN_FTIM], s.main[MAIN_FTIM]))
        else $error("timer event lost");

    a_trig_latch: assert property ( // R07
        p_latch(frame_trig_evt, s.main_en[MAIN_FTRIG], s.main[MAIN_FTRIG]))
        else $error("trigger event lost");

    a_conv_latch: assert property ( // R08
        p_latch(dac_conv_evt[3], s.main_en[MAIN_CONV_LSB+3], s.main[MAIN_CONV_LSB+3]))
        else $error("converter four update lost");

    a_done_latch: assert property ( // R10
        p_latch(seq_conv_done_evt, s.main_en[MAIN_SEQ_DONE], s.main[MAIN_SEQ_DONE]))
        else $error("conversions complete lost");

    a_buf_latch: assert property ( // R11
        p_latch(seq_buf_done_evt, s.main_en[MAIN_BUF_DONE], s.main[MAIN_BUF_DONE]))
        else $error("buffer complete lost");

    a_frame_halt: assert property (seq_frame_err_evt |=> seq_stop) // R12
        else $error("frame error did not stop sequencer");

    a_time_halt: assert property ( // R13
        (seq_time_err_evt && s.err_en[ERR_TIME]) |=> seq_stop && s.err[ERR_TIME])
        else $error("timing error not handled");

    a_data_latch: assert property ( // R14
        p_latch(seq_data_err_evt, s.err_en[ERR_DATA], s.err[ERR_DATA]))
        else $error("data error lost");

    a_xfer_stop: assert property (seq_xfer_err_evt |=> dma_stop && s.err[ERR_XFER]) // R15
        else $error("transfer error not handled");

    a_fault_latch: assert property ( // R16
        ($fell(dac_fault_n[0]) && s.err_en[ERR_FAULT_LSB]) |=> s.err[ERR_FAULT_LSB])
        else $error("fault pin assertion lost");

    a_fault_gate: assert property ( // R17
        (!s.err_en[ERR_FAULT_LSB] && !s.err[ERR_FAULT_LSB]) |=> !s.err[ERR_FAULT_LSB])
        else $error("disabled fault flag became set");

    a_read_clear: assert property ( // R19
        (access && !pwrite && paddr == OFF_MAIN && s.ack_mode == ACK_READ
         && prdata[MAIN_FTIM] && !frame_timer_evt) |=> !s.main[MAIN_FTIM])
        else $error("read did not clear flag");

    a_reserved_zero: assert property ( // R20
        (pready && paddr == OFF_MAIN) |-> (prdata & ~(MAIN_LATCH_MASK | 32'hC000_0000)) == 0)
        else $error("reserved bits not zero");

    a_dio_irq: assert property ($rose(|dio.flags) |=> !irq_n) // R04 R01
        else $error("digital input flag did not raise the interrupt");

    a_err_irq: assert property ($rose(|s.err) |=> !irq_n) // R05 R01
        else $error("error flag did not raise the interrupt");

    a_frame_latch: assert property ( // R12
        p_latch(seq_frame_err_evt, s.err_en[ERR_FRAME], s.err[ERR_FRAME]))
        else $error("frame error lost");

    a_stop_cause: assert property ( // R12 R13
        seq_stop |-> $past(seq_frame_err_evt || seq_time_err_evt))
        else $error("sequencer stop without an error");

    a_dma_cause: assert property (dma_stop |-> $past(seq_xfer_err_evt)) // R15
        else $error("engine stop without a transfer error");

    a_fault_four: assert property ( // R16
        ($fell(dac_fault_n[3]) && s.err_en[ERR_FAULT_LSB+3]) |=> s.err[ERR_FAULT_LSB+3])
        else $error("converter four fault lost");

    a_frame_gate: assert property ( // R02
        (!s.err_en[ERR_FRAME] && !s.err[ERR_FRAME]) |=> !s.err[ERR_FRAME])
        else $error("disabled frame error flag became set");

    a_err_read_clear: assert property ( // R19
        (access && !pwrite && paddr == OFF_ERR && s.ack_mode == ACK_READ
         && prdata[ERR_DATA] && !seq_data_err_evt) |=> !s.err[ERR_DATA])
        else $error("read did not clear error flag");

    a_read_keeps: assert property ( // R03
        (access && !pwrite && s.ack_mode == ACK_WRITE && s.main[MAIN_FTIM])
        |=> s.main[MAIN_FTIM])
        else $error("read cleared a flag in write-clear mode");

    a_dio_read_clear: assert property ( // R19
        (access && !pwrite && paddr == OFF_DIO && s.ack_mode == ACK_READ)
        |-> dio.clr == prdata[DIO_N-1:0])
        else $error("digital input read clear mismatched");

    a_conv_one: assert property ( // R08
        p_latch(dac_conv_evt[0], s.main_en[MAIN_CONV_LSB], s.main[MAIN_CONV_LSB]))
        else $error("converter one update lost");

    a_err_reserved: assert property ( // R20
        (pready && paddr == OFF_ERR) |-> (prdata & ~ERR_MASK) == RST_ZERO)
        else $error("reserved error bits not zero");

    a_err_write_clear: assert property ( // R03
        (access && pwrite && paddr == OFF_ERR && s.ack_mode == ACK_WRITE
         && pwdata[ERR_DATA] && !seq_data_err_evt) |=> !s.err[ERR_DATA])
        else $error("write-one clear of error flag failed");

    c_irq_raise:  cover property ($fell(irq_n));
    c_read_clear: cover property (access && !pwrite && paddr == OFF_MAIN && prdata != 0);
    c_w1c:        cover property (access && pwrite && s.ack_mode == ACK_WRITE);
    c_dio_sum:    cover property (main_view[MAIN_DIO_SUM]);
    c_err_w1c:    cover property (access && pwrite && paddr == OFF_ERR && s.ack_mode == ACK_WRITE);

endmodule // ddis_top

// file: ddis_host_model.sv
// Behavioural host that watches the interrupt request line of the block.
`timescale 1ns/100ps
module ddis_host_model (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic irq_n,
    output int        irq_count
);

    logic irq_q;

    ////////////////////////////////////////////////////////////////////////////
    // Counting falling edges shows a line that is stuck low as well as a missed request.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q     <= 1'b1;
            irq_count <= 0;
        end else begin
            irq_q <= irq_n;
            if (irq_q && !irq_n) begin
                irq_count <= irq_count + 1;
            end
        end
    end

endmodule // ddis_host_model

// file: tb.sv
// Self-checking testbench for the interrupt status block.
`timescale 1ns/100ps
module tb;
    import ddis_pkg::*;

    logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_n;
    logic              seq_stop, dma_stop, rerr;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, rdat;
    logic [11:0]       ev;
    logic [DAC_N-1:0]  dac_fault_n;
    logic [DIO_N-1:0]  dio_in;
    int                miscompares, tests_run, stop_cnt, dma_cnt, irq_count, k;

    ddis_top ddis_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .frame_timer_evt(ev[0]), .frame_trig_evt(ev[1]),
        .dac_conv_evt(ev[5:2]), .seq_conv_done_evt(ev[6]), .seq_buf_done_evt(ev[7]),
        .seq_frame_err_evt(ev[8]), .seq_time_err_evt(ev[9]), .seq_data_err_evt(ev[10]),
        .seq_xfer_err_evt(ev[11]), .dac_fault_n(dac_fault_n), .dio_in(dio_in),
        .irq_n(irq_n), .seq_stop(seq_stop), .dma_stop(dma_stop));

    ddis_host_model ddis_host_model_i (.pclk(pclk), .presetn(presetn), .irq_n(irq_n),
        .irq_count(irq_count));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        stop_cnt += int'(seq_stop === 1'b1);
        dma_cnt  += int'(dma_stop === 1'b1);
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // The request is held until pready is seen high; only then is it released.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0000_0000);
        chk(rdat, exp, what);
    endtask

    task automatic pulse(input int i);
        @(posedge pclk);
        ev[i] <= 1'b1;
        @(posedge pclk);
        ev[i] <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask

    function automatic int bitpos(input int i);
        case (i)
            0: return MAIN_FTIM;
            1: return MAIN_FTRIG;
            6: return MAIN_SEQ_DONE;
            7: return MAIN_BUF_DONE;
            8: return ERR_FRAME;
            9: return ERR_TIME;
            10: return ERR_DATA;
            11: return ERR_XFER;
            default: return MAIN_CONV_LSB + i - 2;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_main();
        for (k = 0; k < 8; k++) pulse(k);
        rd(OFF_MAIN, RST_ZERO, "disabled events");
        apb(1'b1, OFF_MAIN_EN, MAIN_LATCH_MASK);
        for (k = 0; k < 8; k++) begin
            pulse(k);
            chk(32'(irq_n), 32'h0000_0000, "irq active");
            rd(OFF_MAIN, 32'h1 << bitpos(k), "main flag");
            rd(OFF_MAIN, RST_ZERO, "cleared by read");
            chk(32'(irq_n), 32'h0000_0001, "irq released");
        end
        chk(32'(irq_count), 32'h0000_0008, "host saw requests");
        $display("test main done");
    endtask

    task automatic t_err();
        apb(1'b1, OFF_ERR_EN, RST_ZERO);
        dac_fault_n[0] <= 1'b0;
        repeat (3) @(posedge pclk);
        dac_fault_n[0] <= 1'b1;
        rd(OFF_ERR, RST_ZERO, "fault disabled");
        apb(1'b1, OFF_ERR_EN, ERR_MASK);
        for (k = 8; k < 12; k++) begin
            stop_cnt = 0;
            dma_cnt  = 0;
            pulse(k);
            chk(32'(stop_cnt), 32'(k < 10), "sequencer stop");
            chk(32'(dma_cnt), 32'(k == 11), "engine stop");
            rd(OFF_MAIN, 32'h1 << MAIN_ERR_SUM, "error summary");
            rd(OFF_ERR, 32'h1 << bitpos(k), "sequencer error flag");
        end
        for (k = 0; k < DAC_N; k++) begin
            dac_fault_n[k] <= 1'b0;
            repeat (3) @(posedge pclk);
            rd(OFF_ERR, 32'h1 << k, "fault flag");
            dac_fault_n[k] <= 1'b1;
        end
        $display("test error done");
    endtask

    task automatic t_dio();
        apb(1'b1, OFF_RISE_EN, 32'h0000_0001);
        apb(1'b1, OFF_FALL_EN, 32'h0000_0002);
        dio_in[1:0] <= 2'b11;
        repeat (3) @(posedge pclk);
        rd(OFF_MAIN, 32'h1 << MAIN_DIO_SUM, "dio summary");
        rd(OFF_DIO, 32'h0000_0001, "rising only");
        dio_in[1:0] <= 2'b00;
        repeat (3) @(posedge pclk);
        rd(OFF_DIO, 32'h0000_0002, "falling only");
        apb(1'b1, OFF_RISE_EN, 32'h0000_0003);
        dio_in[1] <= 1'b1;
        repeat (3) @(posedge pclk);
        rd(OFF_DIO, 32'h0000_0002, "both edges");
        rd(OFF_MAIN, RST_ZERO, "summary gone");
        $display("test dio done");
    endtask

    task automatic t_ack();
        apb(1'b1, OFF_ERR, 32'hFFFF_FFFF);
        rd(OFF_ERR, RST_ZERO, "write ignored");
        apb(1'b1, OFF_GCFG, 32'h0000_0001);
        pulse(0);
        rd(OFF_MAIN, 32'h1 << MAIN_FTIM, "read keeps flag");
        rd(OFF_MAIN, 32'h1 << MAIN_FTIM, "flag still set");
        apb(1'b1, OFF_MAIN, 32'h1 << MAIN_FTIM);
        rd(OFF_MAIN, RST_ZERO, "write one clears");
        pulse(10);
        rd(OFF_ERR, 32'h1 << ERR_DATA, "error read keeps");
        apb(1'b1, OFF_ERR, 32'h1 << ERR_DATA);
        rd(OFF_ERR, RST_ZERO, "error write one clears");
        apb(1'b1, OFF_GCFG, RST_ZERO);
        rd(12'h000, RST_ZERO, "unmapped data");
        chk(32'(rerr), 32'h0000_0001, "unmapped error");
        $display("test ack done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // The whole sequence needs well under two thousand cycles.
    initial begin
        repeat (20000) @(posedge pclk);
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        miscompares++;
        results();
    end

    initial begin
        {presetn, psel, penable, pwrite} = 4'h0;
        {paddr, pwdata, ev, dio_in} = '0;
        dac_fault_n = 4'hF;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        chk(32'(irq_n), 32'h0000_0001, "irq after reset");
        rd(OFF_MAIN, RST_ZERO, "main reset");
        rd(OFF_ERR, RST_ZERO, "error reset");
        rd(OFF_ERR_EN, RST_ZERO, "fault enables reset");
        t_main();
        t_err();
        t_dio();
        t_ack();
        results();
    end

endmodule // tb
